// ### core/ocmp_pkg.sv
/*
 * package for the output compare channel: register map, field layout,
 * reset values and mode encodings.
 * assumes a 32-bit classic wishbone bus with word-aligned registers.
 */
package ocmp_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_COMPARE = 8'h04;
	localparam logic [7:0] OFF_DUTY = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_STATE = 8'h14;

	// ==========================================================
	// control field positions
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_FAULT = 4;
	localparam int BIT_TBSEL = 3;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 3;
	localparam logic [15:0] CTRL_WMASK = 16'h200f;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] CMP_RESET = 16'h0000;

	// ==========================================================
	// status / mask bits
	localparam int EVT_W = 2;
	localparam int EVT_MATCH = 0;
	localparam int EVT_FAULT = 1;

	// ==========================================================
	// mode encodings
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_SET_HI = 3'b001,
		MODE_SET_LO = 3'b010,
		MODE_TOGGLE = 3'b011,
		MODE_ONE_PULSE = 3'b100,
		MODE_CONT_PULSE = 3'b101,
		MODE_PWM = 3'b110,
		MODE_PWM_FLT = 3'b111
	} mode_type;

	// carrier for the two selectable timebase counts
	typedef struct packed {
		logic [15:0] second_timebase;
		logic [15:0] first_timebase;
	} timebase_type;

endpackage

// ### core/ocmp_sync.sv
/*
 * two-flip-flop synchroniser for asynchronous single-bit levels.
 * assumes the first stage feeds only the second stage.
 */
`timescale 1ns/100ps
`default_nettype none
module ocmp_sync
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic din,
	output logic dout
);
	logic meta_r;
	logic meta_nxt;
	logic dout_nxt;

	// ==========================================================
	// two stages; only the second one is ever read
	always_comb
	begin
		meta_nxt = din;
		dout_nxt = meta_r;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= 1'b0;
			dout <= 1'b0;
		end
		else
		begin
			meta_r <= meta_nxt;
			dout <= dout_nxt;
		end
	end
endmodule // ocmp_sync
`default_nettype wire

// ### core/output_compare_channel.sv
/*
 * output compare channel: compares a selected 16-bit timebase against a
 * stored value and drives the compare output pin in one of eight modes.
 * assumes the timebase counts arrive on CLK_SYS, the fault pin and the
 * idle indication are asynchronous, and software uses classic wishbone.
 */
`timescale 1ns/100ps
`default_nettype none
module output_compare_channel
	import ocmp_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire timebase_type TIMEBASE,
	input wire logic CPU_IDLE,
	input wire logic FAULT_PIN_N,
	output logic COMPARE_OUTPUT_PIN,
	output logic IRQ
);
	logic rst_meta_r;
	logic rst_n;
	logic idle_s;
	logic fault_n_s;

	// ==========================================================
	// reset release through two flops, constants only under reset
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	// pin inputs synchronised before any logic reads them
	ocmp_sync u_sync_idle (.clk(CLK_SYS), .rst_n(rst_n), .din(CPU_IDLE), .dout(idle_s));
	ocmp_sync u_sync_flt (.clk(CLK_SYS), .rst_n(rst_n), .din(FAULT_PIN_N), .dout(fault_n_s));

	// ==========================================================
	// register state
	logic idle_stop_ctl_r, idle_stop_ctl_nxt;
	logic pwm_fault_flag_r, pwm_fault_flag_nxt;
	logic timebase_select_r, timebase_select_nxt;
	mode_type compare_mode_sel_r, compare_mode_sel_nxt;
	logic [15:0] cmp_r, cmp_nxt;
	logic [15:0] duty_r, duty_nxt;
	logic [EVT_W-1:0] status_r, status_nxt;
	logic [EVT_W-1:0] mask_r, mask_nxt;
	logic [31:0] rdata_nxt;
	logic ack_nxt;
	logic out_r, out_nxt;
	logic pulse_done_r, pulse_done_nxt;
	logic [15:0] count;
	logic active;
	logic match;
	logic period_match;
	logic fault_evt;
	logic wr;
	logic rd;
	logic [15:0] ctrl_view;

	assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
	assign rd = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
	// the selected timebase feeds the comparator
	assign count = timebase_select_r ? TIMEBASE.second_timebase : TIMEBASE.first_timebase;
	// halted while idle if asked, and mode 000 never matches and only holds the pin low
	assign active = (compare_mode_sel_r != MODE_OFF) && !(idle_stop_ctl_r && idle_s);
	assign match = active && (count == cmp_r);
	// pwm period ends where the timer wraps to zero; compare register sets the high width, duty register is unused
	assign period_match = active && (count == 16'h0000);
	assign fault_evt = (compare_mode_sel_r == MODE_PWM_FLT) && !fault_n_s && !pwm_fault_flag_r;
	// unimplemented bits are constant zero in the view
	assign ctrl_view = {2'b00, idle_stop_ctl_r, 8'h00, pwm_fault_flag_r, timebase_select_r,
		compare_mode_sel_r};

	// ==========================================================
	// bus slave: one-cycle ack, unmapped reads return zero
	always_comb
	begin
		idle_stop_ctl_nxt = idle_stop_ctl_r;
		timebase_select_nxt = timebase_select_r;
		compare_mode_sel_nxt = compare_mode_sel_r;
		cmp_nxt = cmp_r;
		duty_nxt = duty_r;
		mask_nxt = mask_r;
		rdata_nxt = 32'h0000_0000;
		ack_nxt = WB_CYC_I && WB_STB_I && !WB_ACK_O;
		if (wr && WB_SEL_I[0] && WB_SEL_I[1])
		begin
			case (WB_ADR_I)
				OFF_CONTROL:
				begin
					idle_stop_ctl_nxt = WB_DAT_I[BIT_IDLE_STOP];
					timebase_select_nxt = WB_DAT_I[BIT_TBSEL];
					compare_mode_sel_nxt = mode_type'(WB_DAT_I[MODE_LSB +: MODE_W]);
				end
				OFF_COMPARE: cmp_nxt = WB_DAT_I[15:0];
				OFF_DUTY: duty_nxt = WB_DAT_I[15:0];
				OFF_MASK: mask_nxt = WB_DAT_I[EVT_W-1:0];
				default: ;
			endcase
		end
		if (rd)
		begin
			case (WB_ADR_I)
				OFF_CONTROL: rdata_nxt = {16'h0000, ctrl_view};
				OFF_COMPARE: rdata_nxt = {16'h0000, cmp_r};
				OFF_DUTY: rdata_nxt = {16'h0000, duty_r};
				OFF_STATUS: rdata_nxt = {30'h0, status_r};
				OFF_MASK: rdata_nxt = {30'h0, mask_r};
				OFF_STATE: rdata_nxt = {31'h0, out_r};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// fault flag and sticky status; set beats the read-clear
	always_comb
	begin
		pwm_fault_flag_nxt = pwm_fault_flag_r;
		// hardware clears the flag once the fault pin goes inactive or the mode leaves 111; software cannot write it
		if (compare_mode_sel_r != MODE_PWM_FLT || fault_n_s)
			pwm_fault_flag_nxt = 1'b0;
		if (fault_evt)
			pwm_fault_flag_nxt = 1'b1;
		status_nxt = status_r;
		if (rd && WB_ADR_I == OFF_STATUS)
			status_nxt = '0;
		if (match)
			status_nxt[EVT_MATCH] = 1'b1;
		if (fault_evt)
			status_nxt[EVT_FAULT] = 1'b1;
	end

	// ==========================================================
	// output pin behaviour per mode
	always_comb
	begin
		out_nxt = out_r;
		pulse_done_nxt = pulse_done_r;
		if (compare_mode_sel_nxt != compare_mode_sel_r)
		begin
			// entering a mode sets its initial level
			out_nxt = (compare_mode_sel_nxt == MODE_SET_LO);
			pulse_done_nxt = 1'b0;
		end
		else if (active)
		begin
			case (compare_mode_sel_r)
				MODE_SET_HI: if (match) out_nxt = 1'b1;
				MODE_SET_LO: if (match) out_nxt = 1'b0;
				MODE_TOGGLE: if (match) out_nxt = !out_r;
				MODE_ONE_PULSE:
				begin
					// rise on compare, fall on duty match, then stay low
					if (match && !pulse_done_r)
						out_nxt = 1'b1;
					else if (out_r && count == duty_r)
					begin
						out_nxt = 1'b0;
						pulse_done_nxt = 1'b1;
					end
				end
				MODE_CONT_PULSE:
				begin
					if (match)
						out_nxt = 1'b1;
					else if (count == duty_r)
						out_nxt = 1'b0;
				end
				MODE_PWM, MODE_PWM_FLT:
				begin
					// high from wrap until compare; fault forces low in 111 only
					if (period_match)
						out_nxt = (cmp_r != 16'h0000);
					else if (match)
						out_nxt = 1'b0;
					if (compare_mode_sel_r == MODE_PWM_FLT && (pwm_fault_flag_r || !fault_n_s))
						out_nxt = 1'b0;
				end
				default: out_nxt = out_r;
			endcase
		end
		else if (compare_mode_sel_r == MODE_OFF)
			out_nxt = 1'b0;
	end

	// ==========================================================
	// registers
	always_ff @(posedge CLK_SYS or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idle_stop_ctl_r <= CTRL_RESET[BIT_IDLE_STOP];
			pwm_fault_flag_r <= CTRL_RESET[BIT_FAULT];
			timebase_select_r <= CTRL_RESET[BIT_TBSEL];
			compare_mode_sel_r <= MODE_OFF;
			cmp_r <= CMP_RESET;
			duty_r <= CMP_RESET;
			status_r <= '0;
			mask_r <= '0;
			WB_DAT_O <= 32'h0000_0000;
			WB_ACK_O <= 1'b0;
			out_r <= 1'b0;
			pulse_done_r <= 1'b0;
			COMPARE_OUTPUT_PIN <= 1'b0;
			IRQ <= 1'b0;
		end
		else
		begin
			idle_stop_ctl_r <= idle_stop_ctl_nxt;
			pwm_fault_flag_r <= pwm_fault_flag_nxt;
			timebase_select_r <= timebase_select_nxt;
			compare_mode_sel_r <= compare_mode_sel_nxt;
			cmp_r <= cmp_nxt;
			duty_r <= duty_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			WB_DAT_O <= rdata_nxt;
			WB_ACK_O <= ack_nxt;
			out_r <= out_nxt;
			pulse_done_r <= pulse_done_nxt;
			COMPARE_OUTPUT_PIN <= out_nxt;
			IRQ <= |(status_nxt & mask_nxt);
		end
	end

	// ==========================================================
	// assertions
	property p_idle_halt;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(idle_stop_ctl_r && idle_s && compare_mode_sel_nxt == compare_mode_sel_r)
			|-> !match ##1 $stable(COMPARE_OUTPUT_PIN);
	endproperty
	a_idle_halt: assert property (p_idle_halt) else $error("match while halted in idle");

	property p_fault_set;
		@(posedge CLK_SYS) disable iff (!rst_n)
		fault_evt |=> pwm_fault_flag_r && status_r[EVT_FAULT];
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not flagged");

	property p_fault_only_111;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(compare_mode_sel_r != MODE_PWM_FLT) |=> !pwm_fault_flag_r || $past(fault_evt);
	endproperty
	a_fault_only_111: assert property (p_fault_only_111) else $error("fault flag outside mode 111");

	property p_tbsel;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(active && (TIMEBASE.first_timebase == cmp_r) != (TIMEBASE.second_timebase == cmp_r))
			|-> match == (timebase_select_r == (TIMEBASE.second_timebase == cmp_r));
	endproperty
	a_tbsel: assert property (p_tbsel) else $error("wrong timebase");

	property p_pwm_fault_low;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(compare_mode_sel_r == MODE_PWM_FLT && $past(compare_mode_sel_r) == MODE_PWM_FLT
			&& compare_mode_sel_nxt == MODE_PWM_FLT && pwm_fault_flag_r && active) |=> !COMPARE_OUTPUT_PIN;
	endproperty
	a_pwm_fault_low: assert property (p_pwm_fault_low) else $error("pwm high under fault");

	property p_toggle;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(compare_mode_sel_r == MODE_TOGGLE && match && compare_mode_sel_nxt == MODE_TOGGLE)
			|=> COMPARE_OUTPUT_PIN != $past(COMPARE_OUTPUT_PIN);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle missed");

	property p_set_hi;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(compare_mode_sel_r == MODE_SET_HI && match && compare_mode_sel_nxt == MODE_SET_HI)
			|=> COMPARE_OUTPUT_PIN ##1 COMPARE_OUTPUT_PIN || $changed(compare_mode_sel_r);
	endproperty
	a_set_hi: assert property (p_set_hi) else $error("match did not force high");

	property p_init_lo_hi;
		@(posedge CLK_SYS) disable iff (!rst_n)
		$changed(compare_mode_sel_r) |-> COMPARE_OUTPUT_PIN == (compare_mode_sel_r == MODE_SET_LO);
	endproperty
	a_init_lo_hi: assert property (p_init_lo_hi) else $error("wrong initial level");

	property p_off_quiet;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(compare_mode_sel_r == MODE_OFF)[*2] |-> !COMPARE_OUTPUT_PIN && !match;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("activity while disabled");

	property p_ctrl_zero;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(rd && WB_ADR_I == OFF_CONTROL) |=> (WB_DAT_O & ~32'(CTRL_WMASK | 16'h0010)) == 32'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("unimplemented bits nonzero");

	property p_match_def;
		@(posedge CLK_SYS) disable iff (!rst_n)
		(active && count == cmp_r) |=> status_r[EVT_MATCH];
	endproperty
	a_match_def: assert property (p_match_def) else $error("match not recorded");

	c_toggle: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
		compare_mode_sel_r == MODE_TOGGLE && match);
	c_fault: cover property (@(posedge CLK_SYS) disable iff (!rst_n) fault_evt);
	c_one_pulse: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
		compare_mode_sel_r == MODE_ONE_PULSE && pulse_done_r);
	c_irq: cover property (@(posedge CLK_SYS) disable iff (!rst_n) IRQ);
endmodule // output_compare_channel
`default_nettype wire

// ### test/pin_load_model.sv
/*
 * load hung on the compare output pin: counts low to high steps.
 * assumes the pin is a registered level on clk.
 */
`timescale 1ns/100ps
`default_nettype none
module pin_load_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic [15:0] rise_count
);
	// ==========================================================
	// edge counter
	logic last_r;
	// counting at the load shows pulses the bus cannot sample in time
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			last_r <= 1'b0;
			rise_count <= 16'h0000;
		end
		else
		begin
			last_r <= pin;
			if (pin && !last_r)
				rise_count <= rise_count + 16'h0001;
		end
endmodule // pin_load_model
`default_nettype wire

// ### test/tb_top.sv
/*
 * self-checking bench for the output compare channel.
 * assumes the bench drives both timebases; the first wraps at 199.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import ocmp_pkg::*;
;
	// ==========================================================
	// stimulus signals
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] q;
	logic ack;
	logic [15:0] cnt = 16'h0000;
	logic [15:0] sec = 16'h0000;
	timebase_type tbase;
	logic idle = 1'b0;
	logic flt_n = 1'b1;
	logic pin;
	logic irq;
	logic [15:0] rises;
	logic [15:0] r0;
	int num_errors = 0;
	int checks = 0;
	int tick = 0;

	output_compare_channel i_dut (.CLK_SYS(clk), .ARST_N(arst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .TIMEBASE(tbase), .CPU_IDLE(idle), .FAULT_PIN_N(flt_n),
		.COMPARE_OUTPUT_PIN(pin), .IRQ(irq));
	pin_load_model i_load (.clk(clk), .rst_n(arst_n), .pin(pin), .rise_count(rises));

	// ==========================================================
	// clock, timebases, timeout
	initial
		forever #50 clk = ~clk;
	assign tbase = {sec, cnt};
	// the first timebase wraps short so pulse modes repeat quickly
	always @(posedge clk)
	begin
		cnt <= (cnt == 16'h00c7) ? 16'h0000 : cnt + 16'h0001;
		tick++;
		if (tick == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	// ==========================================================
	// shared tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one classic cycle; request held until ack is sampled high
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// no cycle count assumed; only the bench timeout ends this wait
		while (ack !== 1'b1)
			@(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk({31'h0, ack}, 32'h1);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	// one single-cycle match on the second timebase at 0x012c
	task hit;
		@(posedge clk);
		sec <= 16'h012c;
		@(posedge clk);
		sec <= 16'h0000;
		repeat (4) @(posedge clk);
	endtask
	// write the mode mid-period so no match or wrap lands on a window edge
	task rise_chk(input logic [31:0] ctrl, input logic [15:0] e);
		while (cnt != 16'h0064)
			@(posedge clk);
		wr(OFF_CONTROL, ctrl);
		r0 = rises;
		repeat (600) @(posedge clk);
		chk({16'h0, rises - r0}, {16'h0, e});
	endtask

	// ==========================================================
	// scenarios
	task t_regs;
		rdchk(OFF_CONTROL, {16'h0, CTRL_RESET});
		rdchk(OFF_COMPARE, {16'h0, CMP_RESET});
		rdchk(8'h20, 32'h0);
		wr(OFF_CONTROL, 32'hffffffff);
		rdchk(OFF_CONTROL, {16'h0, CTRL_WMASK});
	endtask
	task t_levels;
		wr(OFF_COMPARE, 32'h012c);
		wr(OFF_CONTROL, 32'h0001);
		hit();
		rdchk(OFF_STATE, 32'h0);
		wr(OFF_CONTROL, 32'h0009);
		rdchk(OFF_STATE, 32'h0);
		hit();
		rdchk(OFF_STATE, 32'h1);
		wr(OFF_CONTROL, 32'h000a);
		rdchk(OFF_STATE, 32'h1);
		hit();
		rdchk(OFF_STATE, 32'h0);
		wr(OFF_CONTROL, 32'h000b);
		hit();
		rdchk(OFF_STATE, 32'h1);
		hit();
		rdchk(OFF_STATE, 32'h0);
	endtask
	task t_idle;
		idle <= 1'b1;
		wr(OFF_CONTROL, 32'h200b);
		hit();
		rdchk(OFF_STATE, 32'h0);
		wr(OFF_CONTROL, 32'h000b);
		hit();
		rdchk(OFF_STATE, 32'h1);
		idle <= 1'b0;
	endtask
	task t_pulses;
		wr(OFF_COMPARE, 32'h0032);
		wr(OFF_DUTY, 32'h0050);
		rise_chk(32'h0000, 16'h0000);
		rise_chk(32'h0004, 16'h0001);
		rise_chk(32'h0005, 16'h0003);
		flt_n <= 1'b0;
		rise_chk(32'h0006, 16'h0003);
		rise_chk(32'h0007, 16'h0000);
		rdchk(OFF_CONTROL, 32'h0017);
		rdchk(OFF_STATUS, 32'h0003);
		wr(OFF_CONTROL, 32'h0007);
		rdchk(OFF_CONTROL, 32'h0017);
		flt_n <= 1'b1;
		repeat (10) @(posedge clk);
		rdchk(OFF_CONTROL, 32'h0007);
		rise_chk(32'h0007, 16'h0003);
	endtask
	task t_irq;
		wr(OFF_COMPARE, 32'h012c);
		wr(OFF_CONTROL, 32'h0009);
		wr(OFF_MASK, 32'h0001);
		bus(1'b0, OFF_STATUS, 32'h0);
		hit();
		chk({31'h0, irq}, 32'h1);
		rdchk(OFF_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		rdchk(OFF_STATUS, 32'h0);
		wr(OFF_MASK, 32'h0000);
		hit();
		chk({31'h0, irq}, 32'h0);
		rdchk(OFF_STATUS, 32'h1);
	endtask

	// ==========================================================
	// verdict and main sequence
	task give_verdict;
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// reset is released on an edge, then the synchroniser settles
	initial
	begin
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_regs();
		t_levels();
		t_idle();
		t_pulses();
		t_irq();
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
